// File: core/bnf_defines.svh
// Shared constants for the burst NOR flash link: commands, geometry, timing
// =====================================================================
// Contract
// - Every read transfer drives all 16 bits
// - Every write transfer carries all 16 bits
// - Rest of aligned 16-word group bursts quickly
// - Burst types: wrap 8, wrap 16, continuous
// - Wrap runs to group end, then group start
// - Wrap ends before start word, each once
// - Continuous delivers rising addresses until host ends
// - Continuous waits at each 16-word boundary
// - Ready low in waits; host ignores data
// - Async fast read within same cache line
// - Sixteen banks; read others during program
// - Sector erase sets all sector bits one
// - Top boot: four 32 KByte top sectors
// - Uniform variant: all sectors 128 KBytes
// - Program through 512-byte buffer, aligned pages
// - One program: one bit to 512 bytes
// - Host programs each page once per erase; host refuses a second plain program only for its last programmed page
// - Bit-field programming may repeat on page
// - Program clears bits only; erase sets them
// - Dual enable uses A24; single uses A25
// - Burst address latched while strobe low
// - Each burst edge advances address counter
// - Busy bank reads give stable undefined data
`ifndef BNF_DEFINES_SVH
`define BNF_DEFINES_SVH

// =====================================================================
// Bus geometry
`define BNF_AW          26
`define BNF_DW          16
`define BNF_TOP_BIT     25
`define BNF_BANK_LSB    22
`define BNF_LINE_LSB    4
`define BNF_PAGE_LSB    8
`define BNF_SECT_LSB    16
`define BNF_BOOT_LSB    14
`define BNF_PAGE_WORDS  256
`define BNF_SECT_LAST   16'hffff
`define BNF_BOOT_LAST   16'h3fff
`define BNF_ERASED      16'hffff
`define BNF_BUSY_WORD   16'hffff
`define BNF_IDLE_WORD   16'hffff

// =====================================================================
// Command words and configuration fields
`define BNF_CMD_CFG     16'h00c0
`define BNF_CMD_PROG    16'h0025
`define BNF_CMD_CONFIRM 16'h0029
`define BNF_CMD_ERASE   16'h0030
`define BNF_CFG_SYNC    2
`define BNF_CFG_BURST   1:0
`define BNF_BT_CONT     2'h0
`define BNF_BT_WRAP8    2'h1
`define BNF_BT_WRAP16   2'h2

// =====================================================================
// Timing at 125 MHz
`define BNF_CLK_NS      8
`define BNF_T_ACC_NS    115
`define BNF_T_ICACC_NS  20
`define BNF_ACC_CYC     ((`BNF_T_ACC_NS + `BNF_CLK_NS - 1) / `BNF_CLK_NS)
`define BNF_ICACC_CYC   ((`BNF_T_ICACC_NS + `BNF_CLK_NS - 1) / `BNF_CLK_NS)
`define BNF_LEN_WRAP8   5'h08
`define BNF_LEN_WRAP16  5'h10

`endif

// File: core/bnf_pkg.sv
// Types shared by both ends of the burst NOR flash link
package bnf_pkg;
  typedef enum logic [1:0] {
    BNF_BURST_CONT,
    BNF_BURST_WRAP8,
    BNF_BURST_WRAP16
  } bnf_burst_t;

  typedef enum logic {
    BNF_OP_READ,
    BNF_OP_WRITE
  } bnf_op_t;
endpackage

// File: core/bnf_if.sv
// Parallel flash pins between host controller and flash device
`timescale 1ns/1ps
interface bnf_if;
  logic [25:0] addr;
  logic        ce_n;
  logic        upper_half_select_n;
  logic        address_latch_strobe_n;
  logic        oe_n;
  logic        we_n;
  logic [15:0] h_dq_o;
  logic        h_dq_oe_n;
  logic [15:0] d_dq_o;
  logic        d_dq_oe_n;
  logic [15:0] dq;
  logic        rdy;

  // Wire level of the shared data pins; floating bus reads as all ones
  assign dq = !h_dq_oe_n ? h_dq_o : (!d_dq_oe_n ? d_dq_o : 16'hffff);

  modport host (output addr, ce_n, upper_half_select_n, address_latch_strobe_n,
                output oe_n, we_n, h_dq_o, h_dq_oe_n, input dq, rdy);
  modport device (input addr, ce_n, upper_half_select_n, address_latch_strobe_n,
                  input oe_n, we_n, dq, output d_dq_o, d_dq_oe_n, rdy);
endinterface

// File: core/bnf_fifo.sv
// Small valid/ready FIFO between the array fetcher and the burst output
`timescale 1ns/1ps
module bnf_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  // Pointer wrap relies on a power-of-two depth
  initial begin
    if (D < 2 || (1 << AW) != D || W < 1) begin
      $error("bnf_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready && !clr;
  assign pop       = out_valid && out_ready && !clr;

  // =====================================================================
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // Pointers and fill level; clear drops everything in flight
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (clr) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop) rp_ff <= rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: core/bnf_dev.sv
// Flash device end: array, banks, program/erase engine, burst and async reads
`timescale 1ns/1ps
`include "bnf_defines.svh"
module bnf_dev #(
  parameter int MEM_AW     = 12,
  parameter bit DUAL_CE    = 1'b0,
  parameter bit TOP_BOOT   = 1'b1,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic  clk,
  input  wire logic  reset_n,
  bnf_if.device      bus,
  output logic       busy,
  output logic [3:0] busy_bank,
  output logic       sync_mode
);
  // Array is a stand-in of 2**MEM_AW words; higher address bits alias
  initial begin
    if (MEM_AW < `BNF_PAGE_LSB || MEM_AW > `BNF_AW || FIFO_DEPTH < 2) begin
      $error("bnf_dev: unsupported array or fifo size");
    end
  end

  typedef enum logic [2:0] {E_IDLE, E_CFG, E_CNT, E_LOAD, E_CONF, E_PROG, E_ERASE} eng_t;
  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_RUN, F_ADONE} fetch_t;

  // Next burst address: wraps touch only the low group bits
  function automatic logic [25:0] nxt_burst(input logic [25:0] a, input bnf_pkg::bnf_burst_t b);
    unique case (b)
      bnf_pkg::BNF_BURST_WRAP8:  nxt_burst = {a[25:3], a[2:0] + 3'h1};
      bnf_pkg::BNF_BURST_WRAP16: nxt_burst = {a[25:4], a[3:0] + 4'h1};
      default:                   nxt_burst = a + 26'h1;
    endcase
  endfunction

  // Top boot area is the last 128 KByte block split in four
  function automatic logic boot_area(input logic [25:0] a);
    boot_area = TOP_BOOT && (&a[`BNF_TOP_BIT:`BNF_SECT_LSB]);
  endfunction

  logic [15:0] mem_ff [2**MEM_AW];
  logic [15:0] pbuf_ff [`BNF_PAGE_WORDS];
  logic [`BNF_PAGE_WORDS-1:0] pvld_ff;
  eng_t        e_state_ff;
  logic [17:0] page_ff;
  logic [25:0] eptr_ff;
  logic [15:0] eleft_ff;
  bnf_pkg::bnf_burst_t burst_ff;
  fetch_t      f_state_ff;
  logic [25:0] fa_ff;
  logic [4:0]  wait_ff;
  logic [4:0]  push_left_ff;
  logic [4:0]  out_left_ff;
  logic        cont_ff;
  logic [21:0] line_ff;
  logic        line_vld_ff;
  logic [15:0] dq_o_ff;
  logic        dq_oe_n_ff;
  logic        rdy_ff;

  localparam logic [4:0] ACC_CYC   = 5'(`BNF_ACC_CYC);
  localparam logic [4:0] ICACC_CYC = 5'(`BNF_ICACC_CYC);

  // =====================================================================
  // Pin decode; with dual enables, both low at once selects nothing
  logic        sel;
  logic [25:0] eaddr;
  logic        wr_take;
  logic        start;
  logic        ea_busy;
  logic [15:0] rd_word;
  logic        f_valid;
  logic        f_ready;
  logic        f_out_valid;
  logic [15:0] f_out_data;
  logic        pop;

  assign sel = DUAL_CE ? (!bus.ce_n ^ !bus.upper_half_select_n) : !bus.ce_n;
  assign eaddr = DUAL_CE ? {!bus.upper_half_select_n, bus.addr[24:0]} : bus.addr;
  assign wr_take = sel && !bus.we_n && bus.oe_n;
  assign start = sel && !bus.address_latch_strobe_n && bus.we_n;
  assign ea_busy = (e_state_ff == E_PROG) || (e_state_ff == E_ERASE);
  // Busy bank answers a fixed word; other banks read normally
  assign rd_word = (ea_busy && fa_ff[25:22] == eptr_ff[25:22]) ? `BNF_BUSY_WORD
                                                             : mem_ff[fa_ff[MEM_AW-1:0]];
  assign f_valid = (f_state_ff == F_RUN);
  assign pop = f_out_valid && sel && !bus.oe_n && (cont_ff || out_left_ff != 5'h00);

  // =====================================================================
  // Program/erase engine, driven by host command words
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      e_state_ff <= E_IDLE;
      page_ff    <= '0;
      eptr_ff    <= '0;
      eleft_ff   <= '0;
      burst_ff   <= bnf_pkg::BNF_BURST_CONT;
      sync_mode  <= 1'b0;
    end else begin
      unique case (e_state_ff)
        E_IDLE: if (wr_take) begin
          if (bus.dq == `BNF_CMD_CFG) e_state_ff <= E_CFG;
          if (bus.dq == `BNF_CMD_PROG) begin
            page_ff    <= eaddr[25:8];
            eptr_ff    <= {eaddr[25:8], 8'h00};
            e_state_ff <= E_CNT;
          end
          if (bus.dq == `BNF_CMD_ERASE) begin
            eptr_ff    <= boot_area(eaddr) ? {eaddr[25:14], 14'h0000}
                                           : {eaddr[25:16], 16'h0000};
            eleft_ff   <= boot_area(eaddr) ? `BNF_BOOT_LAST : `BNF_SECT_LAST;
            e_state_ff <= E_ERASE;
          end
        end
        E_CFG: if (wr_take) begin
          sync_mode  <= bus.dq[`BNF_CFG_SYNC];
          burst_ff   <= bnf_pkg::bnf_burst_t'(bus.dq[`BNF_CFG_BURST]);
          e_state_ff <= E_IDLE;
        end
        E_CNT: if (wr_take) begin
          eleft_ff   <= {8'h00, bus.dq[7:0]};
          e_state_ff <= E_LOAD;
        end
        E_LOAD: if (wr_take) begin
          eleft_ff <= eleft_ff - 16'h1;
          if (eleft_ff == 16'h0) e_state_ff <= E_CONF;
        end
        E_CONF: if (wr_take) begin
          e_state_ff <= (bus.dq == `BNF_CMD_CONFIRM) ? E_PROG : E_IDLE;
        end
        E_PROG: begin
          eptr_ff <= eptr_ff + 26'h1;
          if (eptr_ff[7:0] == 8'hff) e_state_ff <= E_IDLE;
        end
        E_ERASE: begin
          eptr_ff  <= eptr_ff + 26'h1;
          eleft_ff <= eleft_ff - 16'h1;
          if (eleft_ff == 16'h0) e_state_ff <= E_IDLE;
        end
        default: e_state_ff <= E_IDLE;
      endcase
    end
  end

  // Page buffer: only words inside the chosen page are kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pvld_ff <= '0;
    end else if (e_state_ff == E_IDLE && wr_take && bus.dq == `BNF_CMD_PROG) begin
      pvld_ff <= '0;
    end else if (e_state_ff == E_LOAD && wr_take && eaddr[25:8] == page_ff) begin
      pvld_ff[eaddr[7:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (e_state_ff == E_LOAD && wr_take && eaddr[25:8] == page_ff) begin
      pbuf_ff[eaddr[7:0]] <= bus.dq;
    end
  end

  // Array writes: programming can only clear bits, so repeats act as bit-field
  always_ff @(posedge clk) begin
    if (e_state_ff == E_PROG && pvld_ff[eptr_ff[7:0]]) begin
      mem_ff[eptr_ff[MEM_AW-1:0]] <= mem_ff[eptr_ff[MEM_AW-1:0]] & pbuf_ff[eptr_ff[7:0]];
    end else if (e_state_ff == E_ERASE) begin
      mem_ff[eptr_ff[MEM_AW-1:0]] <= `BNF_ERASED;
    end
  end

  assign busy = ea_busy;
  assign busy_bank = eptr_ff[25:22];

  // =====================================================================
  // Read fetcher: initial access, then one word per edge while fifo has room
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f_state_ff   <= F_IDLE;
      fa_ff        <= '0;
      wait_ff      <= '0;
      push_left_ff <= '0;
      line_ff      <= '0;
      line_vld_ff  <= 1'b0;
    end else if (start) begin
      fa_ff      <= eaddr;
      f_state_ff <= F_WAIT;
      push_left_ff <= (burst_ff == bnf_pkg::BNF_BURST_WRAP8)  ? `BNF_LEN_WRAP8 :
                      (burst_ff == bnf_pkg::BNF_BURST_WRAP16) ? `BNF_LEN_WRAP16 : 5'h00;
      // Same line as the last async read skips the array access
      wait_ff <= (!sync_mode && line_vld_ff && eaddr[25:4] == line_ff) ? ICACC_CYC
                                                                       : ACC_CYC;
    end else if (!sel) begin
      f_state_ff <= F_IDLE;
    end else begin
      unique case (f_state_ff)
        F_IDLE: f_state_ff <= F_IDLE;
        F_WAIT: begin
          wait_ff <= wait_ff - 5'h01;
          if (wait_ff <= 5'h01) f_state_ff <= sync_mode ? F_RUN : F_ADONE;
        end
        F_RUN: if (f_ready) begin
          fa_ff <= nxt_burst(fa_ff, burst_ff);
          push_left_ff <= push_left_ff - 5'h01;
          // Last wrap word is the one before the start word
          if (!cont_ff && push_left_ff == 5'h01) f_state_ff <= F_IDLE;
          if (cont_ff && fa_ff[3:0] == 4'hf) begin
            wait_ff    <= ACC_CYC;
            f_state_ff <= F_WAIT;
          end
        end
        F_ADONE: begin
          line_ff     <= fa_ff[25:4];
          line_vld_ff <= !ea_busy;
        end
      endcase
    end
  end

  // Burst bookkeeping for the output side
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_left_ff <= '0;
      cont_ff     <= 1'b0;
    end else if (start) begin
      cont_ff <= (burst_ff == bnf_pkg::BNF_BURST_CONT);
      out_left_ff <= (burst_ff == bnf_pkg::BNF_BURST_WRAP8)  ? `BNF_LEN_WRAP8 :
                     (burst_ff == bnf_pkg::BNF_BURST_WRAP16) ? `BNF_LEN_WRAP16 : 5'h00;
    end else if (pop && !cont_ff) begin
      out_left_ff <= out_left_ff - 5'h01;
    end
  end

  // Fifo decouples array fetch from the host's read pace; flushed per burst
  bnf_fifo #(.W(`BNF_DW), .D(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clr       (start || !sel),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (rd_word),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  // =====================================================================
  // Pin drivers: registered so data and ready change together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_o_ff    <= `BNF_IDLE_WORD;
      dq_oe_n_ff <= 1'b1;
      rdy_ff     <= 1'b0;
    end else begin
      dq_oe_n_ff <= !(sel && !bus.oe_n && bus.we_n);
      if (sync_mode) begin
        rdy_ff <= pop;
        if (pop) dq_o_ff <= f_out_data;
      end else begin
        // Ready drops with output enable so it never outlives the data drive
        rdy_ff <= (f_state_ff == F_ADONE) && sel && !bus.oe_n && !start;
        if (f_state_ff == F_ADONE) dq_o_ff <= rd_word;
      end
    end
  end

  assign bus.d_dq_o    = dq_o_ff;
  assign bus.d_dq_oe_n = dq_oe_n_ff;
  assign bus.rdy       = rdy_ff;
endmodule

// File: core/bnf_host.sv
// Host controller end: single word writes and counted reads over the flash pins
`timescale 1ns/1ps
`include "bnf_defines.svh"
module bnf_host #(
  parameter bit DUAL_CE = 1'b0
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  bnf_if.host                  bus,
  input  wire logic            req_valid,
  output logic                 req_ready,
  input  wire bnf_pkg::bnf_op_t req_op,
  input  wire logic [25:0]     req_addr,
  input  wire logic [15:0]     req_wdata,
  input  wire logic [7:0]      req_len,
  input  wire logic            req_bitfield,
  output logic                 rd_valid,
  output logic [15:0]          rd_data,
  output logic                 refused,
  output logic                 done
);
  typedef enum logic [2:0] {H_IDLE, H_WR, H_LATCH, H_READ, H_END} hstate_t;

  hstate_t     state_ff;
  logic [7:0]  left_ff;
  logic [17:0] last_page_ff;
  logic        last_vld_ff;
  logic [25:0] addr_ff;
  logic        ce_n_ff;
  logic        uhs_n_ff;
  logic        als_n_ff;
  logic        oe_n_ff;
  logic        we_n_ff;
  logic [15:0] dq_o_ff;
  logic        dq_oe_n_ff;
  logic        take;
  logic        reprog;

  assign take = req_valid && req_ready;
  // A second plain program of the last programmed page needs an erase first
  assign reprog = req_op == bnf_pkg::BNF_OP_WRITE && req_wdata == `BNF_CMD_PROG &&
                  last_vld_ff && last_page_ff == req_addr[25:8] && !req_bitfield;

  // =====================================================================
  // Bus sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= H_IDLE;
      left_ff    <= '0;
      addr_ff    <= '0;
      ce_n_ff    <= 1'b1;
      uhs_n_ff   <= 1'b1;
      als_n_ff   <= 1'b1;
      oe_n_ff    <= 1'b1;
      we_n_ff    <= 1'b1;
      dq_o_ff    <= '0;
      dq_oe_n_ff <= 1'b1;
      req_ready  <= 1'b1;
      rd_valid   <= 1'b0;
      rd_data    <= '0;
      refused    <= 1'b0;
      done       <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      refused  <= 1'b0;
      done     <= 1'b0;
      unique case (state_ff)
        H_IDLE: if (take) begin
          if (reprog) begin
            refused <= 1'b1;
          end else begin
            req_ready <= 1'b0;
            // Dual model: top bit picks which enable, A25 pin unused
            addr_ff  <= DUAL_CE ? {1'b0, req_addr[24:0]} : req_addr;
            ce_n_ff  <= DUAL_CE ? req_addr[25] : 1'b0;
            uhs_n_ff <= DUAL_CE ? !req_addr[25] : 1'b1;
            left_ff  <= req_len;
            if (req_op == bnf_pkg::BNF_OP_WRITE) begin
              we_n_ff    <= 1'b0;
              dq_o_ff    <= req_wdata;
              dq_oe_n_ff <= 1'b0;
              state_ff   <= H_WR;
            end else begin
              als_n_ff <= 1'b0;
              state_ff <= H_LATCH;
            end
          end
        end
        H_WR: begin
          we_n_ff    <= 1'b1;
          dq_oe_n_ff <= 1'b1;
          state_ff   <= H_END;
        end
        H_LATCH: begin
          als_n_ff <= 1'b1;
          oe_n_ff  <= 1'b0;
          state_ff <= H_READ;
        end
        H_READ: if (bus.rdy) begin
          rd_valid <= 1'b1;
          rd_data  <= bus.dq;
          left_ff  <= left_ff - 8'h01;
          // Raising enable is what ends a continuous burst
          if (left_ff <= 8'h01) begin
            oe_n_ff  <= 1'b1;
            state_ff <= H_END;
          end
        end
        H_END: begin
          ce_n_ff   <= 1'b1;
          uhs_n_ff  <= 1'b1;
          done      <= 1'b1;
          req_ready <= 1'b1;
          state_ff  <= H_IDLE;
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  // Page program tracking; any erase makes pages programmable again
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_page_ff <= '0;
      last_vld_ff  <= 1'b0;
    end else if (take && req_op == bnf_pkg::BNF_OP_WRITE) begin
      if (req_wdata == `BNF_CMD_PROG && !reprog) begin
        last_page_ff <= req_addr[25:8];
        last_vld_ff  <= 1'b1;
      end else if (req_wdata == `BNF_CMD_ERASE) begin
        last_vld_ff <= 1'b0;
      end
    end
  end

  assign bus.addr                   = addr_ff;
  assign bus.ce_n                   = ce_n_ff;
  assign bus.upper_half_select_n    = uhs_n_ff;
  assign bus.address_latch_strobe_n = als_n_ff;
  assign bus.oe_n                   = oe_n_ff;
  assign bus.we_n                   = we_n_ff;
  assign bus.h_dq_o                 = dq_o_ff;
  assign bus.h_dq_oe_n              = dq_oe_n_ff;
endmodule

// File: verif/bnf_link_properties.sv
// Interface checker for the burst flash link
`timescale 1ns/1ps
module bnf_link_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce_n,
  input wire logic address_latch_strobe_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic h_dq_oe_n,
  input wire logic d_dq_oe_n,
  input wire logic rdy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Pin relations, one cycle slack where outputs come from ff
  read_word_a: assert property (rdy |-> !d_dq_oe_n && h_dq_oe_n)
    else $error("rdy without device data");
  write_word_a: assert property (!we_n |-> !h_dq_oe_n && oe_n && !ce_n)
    else $error("write without host data");
  write_pulse_a: assert property ($fell(we_n) |=> we_n)
    else $error("write strobe too long");
  no_clash_a: assert property (h_dq_oe_n || d_dq_oe_n)
    else $error("both ends drive dq");
  latch_pulse_a: assert property (!address_latch_strobe_n |-> !ce_n && we_n ##1 address_latch_strobe_n)
    else $error("bad address strobe");
  first_wait_a: assert property ($fell(address_latch_strobe_n) |=> !rdy [*2])
    else $error("rdy before access time");
  word_comes_a: assert property ($fell(address_latch_strobe_n) |-> ##[1:40] rdy)
    else $error("no read word");
  idle_quiet_a: assert property (ce_n [*2] |-> !rdy)
    else $error("rdy while deselected");
  // Main traffic seen
  cover property (rdy [*8]);
  cover property ($fell(we_n));
  cover property ($rose(rdy));
endmodule

// File: verif/burst_nor_flash_access_tb.sv
// Self-checking bench: host end and device end joined over the flash pins
`timescale 1ns/1ps
module burst_nor_flash_access_tb;
  logic clk = 0, reset_n = 0, req_valid = 0, req_ready, rd_valid, refused, done;
  logic busy, sync_mode;
  logic [25:0] req_addr = '0;
  logic [15:0] req_wdata = '0, rd_data;
  logic [7:0] req_len = 8'h01;
  logic req_bitfield = 0;
  logic [15:0] pdat [8];
  logic [15:0] bits;
  logic [15:0] cfg [3] = '{16'h0005, 16'h0006, 16'h0004};
  int grp [3] = '{8, 16, 0};
  int blen [3] = '{8, 16, 16};
  bnf_pkg::bnf_op_t req_op = bnf_pkg::BNF_OP_WRITE;
  localparam bnf_pkg::bnf_op_t WR = bnf_pkg::BNF_OP_WRITE;
  localparam bnf_pkg::bnf_op_t RD = bnf_pkg::BNF_OP_READ;
  int error_cnt = 0, checks_done = 0, cyc = 0, last_n = 0, hot_bank = -1;
  bnf_if bus ();
  bnf_dev #(.MEM_AW(8)) bnf_dev_i (.clk(clk), .reset_n(reset_n), .bus(bus), .busy(busy),
    .busy_bank(), .sync_mode(sync_mode));
  bnf_host bnf_host_i (.clk(clk), .reset_n(reset_n), .bus(bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_len(req_len), .req_bitfield(req_bitfield), .rd_valid(rd_valid), .rd_data(rd_data),
    .refused(refused), .done(done));
  bnf_link_properties bnf_link_properties_i (.clk(clk), .reset_n(reset_n), .ce_n(bus.ce_n),
    .address_latch_strobe_n(bus.address_latch_strobe_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
    .h_dq_oe_n(bus.h_dq_oe_n), .d_dq_oe_n(bus.d_dq_oe_n), .rdy(bus.rdy));
  // ==========================================================
  // Clock, and a cycle ceiling above the long erase
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Busy bank reads the fixed word; the stand-in array repeats every 256 words
  function automatic logic [15:0] exp_word(input int a);
    if ((a >> 22) == hot_bank) return 16'hffff;
    a = a % 256;
    return (a < 8) ? pdat[a] : 16'hffff;
  endfunction
  // Access time in whole 8 ns clocks
  function automatic int acc(input int ns);
    return (ns + 7) / 8;
  endfunction
  // Take to done: access, handshake and words, plus a refetch at each 16-word edge of a continuous burst
  function automatic int burst_cyc(input int a, input int len, input int grp);
    return acc(115) + 4 + len + (grp ? 0 : ((a + len - 1) / 16 - a / 16) * acc(115));
  endfunction
  // One user request, driven 1 ns after an edge; read words compared in wrap order, or rising order for continuous
  task automatic xfer(input bnf_pkg::bnf_op_t op, input int a, input logic [15:0] d,
                      input int len, input int grp);
    int i;
    int n;
    i = 0;
    n = 0;
    @(posedge clk);
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_len = len;
    @(posedge clk);
    #1 req_valid = 0;
    while (done !== 1'b1 && refused !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
      if (rd_valid === 1'b1) begin
        check(rd_data, exp_word(grp ? (a & ~(grp - 1)) | ((a + i) & (grp - 1)) : a + i));
        i++;
      end
    end
    if (n >= 400) error_cnt++;
    last_n = n;
    if (op == bnf_pkg::BNF_OP_READ) check(i, len);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 80000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 80000) error_cnt++;
  endtask
  // ==========================================================
  // Erase, program, reads during programming, bit-field pass, async and burst reads
  initial begin
    void'($urandom(32'h57e2));
    repeat (20) @(posedge clk);
    #1 reset_n = 1;
    foreach (pdat[k]) pdat[k] = $urandom;
    pdat[0] = 16'h0000;
    bits = $urandom;
    xfer(WR, 0, 16'h0030, 1, 0);
    wait_idle();
    xfer(RD, 12, 0, 1, 0);
    check(last_n, acc(115) + 4);
    xfer(WR, 0, 16'h0025, 1, 0);
    xfer(WR, 0, 16'h0007, 1, 0);
    foreach (pdat[k]) xfer(WR, k, pdat[k], 1, 0);
    xfer(WR, 0, 16'h0029, 1, 0);
    // Bank 0 programs: bank 1 reads live data, bank 0 the fixed busy word
    hot_bank = 0;
    xfer(RD, 26'h0400000, 0, 1, 0);
    xfer(RD, 0, 0, 1, 0);
    hot_bank = -1;
    wait_idle();
    // Second plain program of the same page without erase is turned away
    xfer(WR, 0, 16'h0025, 1, 0);
    check(refused, 1'b1);
    // Bit-field pass on the same page clears further bits of word 1
    req_bitfield = 1;
    xfer(WR, 0, 16'h0025, 1, 0);
    xfer(WR, 0, 16'h0000, 1, 0);
    xfer(WR, 1, bits, 1, 0);
    xfer(WR, 0, 16'h0029, 1, 0);
    req_bitfield = 0;
    wait_idle();
    pdat[1] = pdat[1] & bits;
    // First async read opens the line, the rest hit it
    for (int k = 0; k < 8; k++) begin
      xfer(RD, k, 0, 1, 0);
      check(last_n, acc(k ? 20 : 115) + 4);
    end
    for (int m = 0; m < 3; m++) begin
      xfer(WR, 0, 16'h00c0, 1, 0);
      xfer(WR, 0, cfg[m], 1, 0);
      check(sync_mode, 1'b1);
      xfer(RD, 5, 0, blen[m], grp[m]);
      check(last_n, burst_cyc(5, blen[m], grp[m]));
    end
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule
